// ===== common/core_exec_pkg.sv
// Types shared by the execution subset block
package core_exec_pkg;

   // One-hot execution state
   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_FLUSH = 3'b010,
      ST_IDLE  = 3'b100
   } exec_state_t;

   // Decoded operation
   typedef enum logic [3:0] {
      OP_NONE, OP_CLR_FILE, OP_CLR_ACC, OP_DEC, OP_DECSKIP, OP_INCSKIP, OP_BRANCH, OP_ORLIT
   } exec_op_t;

   // Write-back to the file register memory
   typedef struct packed {
      logic       en;
      logic [6:0] addr;
      logic [7:0] data;
   } file_wr_t;

   // Program counter load request
   typedef struct packed {
      logic        en;
      logic [14:0] target;
   } pc_load_t;

endpackage

// ===== common/core_exec_regs.svh
// Constants for the instruction execution subset: opcodes, fields, counts
`ifndef CORE_EXEC_REGS_SVH
`define CORE_EXEC_REGS_SVH

// ************************************************************
// Opcode patterns (14-bit instruction word)
// ************************************************************
`define OPC_CLR_FILE_HI 7'h03
`define OPC_CLR_ACC    14'h0100
`define OPC_DEC_HI     6'h03
`define OPC_DECSKIP_HI 6'h0b
`define OPC_INCSKIP_HI 6'h0f
`define OPC_BRANCH_HI  3'h5
`define OPC_ORLIT_HI   6'h38

// ************************************************************
// Field positions and widths
// ************************************************************
`define FILE_ADDR_W    7
`define DEST_BIT       7
`define BRANCH_K_W     11
`define LATCH_LO_BIT   3
`define LATCH_HI_BIT   6
`define PC_W           15
`define DATA_W         8

// ************************************************************
// Reset values and cycle counts
// ************************************************************
`define ACC_RESET      8'h00
`define ZERO_RESET     1'b0
`define SKIP_CYCLES    2
`define BRANCH_CYCLES  2

`endif

// ===== design/core_exec_subset.sv
// Executes a subset of the core instruction set with skip and branch timing
`timescale 1ns/100ps
`include "core_exec_regs.svh"

// Notes on behaviour
// RULE1: Clear register writes zero, sets zero flag
// RULE2: File address 7 bits, destination bit 0/1
// RULE3: Decrement register, destination select, update zero flag
// RULE4: Clear accumulator loads zero, sets zero flag
// RULE5: Decrement-skip stores result, flags untouched
// RULE6: Zero decrement result replaces next with no_operation
// RULE7: Increment-skip stores result, flags untouched
// RULE8: Zero increment result takes two cycles
// RULE9: Branch: k into low, latch 6:3 high
// RULE10: Branch always takes two cycles
// RULE11: OR literal into accumulator, update zero flag
// RULE12: Zero flag equals result zero; wrap 256
module core_exec_subset #(
   parameter int ADDR_W = `FILE_ADDR_W,
   parameter int DATA_W = `DATA_W
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Instruction stream
   input wire logic i_instr_valid,
   input wire logic [13:0] i_instr,
   input wire logic [6:0] i_upper_jump_latch,
   // File register preload port
   input wire logic i_ext_wr_en,
   input wire logic [ADDR_W-1:0] i_ext_wr_addr,
   input wire logic [DATA_W-1:0] i_ext_wr_data,
   // Results
   output logic [DATA_W-1:0] o_accumulator,
   output logic o_zero_flag,
   output core_exec_pkg::pc_load_t o_pc_load,
   output core_exec_pkg::file_wr_t o_file_wr,
   output logic o_no_operation,
   output logic o_busy,
   output logic o_unknown_op
);
   import core_exec_pkg::*;

   // ************************************************************
   // Decode
   // ************************************************************

   // Decoding is shared between the issue stage and the unknown flag
   function automatic exec_op_t decode(input logic [13:0] w);
      exec_op_t r;
      r = OP_NONE;
      if (w[13:7] == `OPC_CLR_FILE_HI) begin
         r = OP_CLR_FILE;
      end else if (w == `OPC_CLR_ACC) begin
         r = OP_CLR_ACC;
      end else if (w[13:8] == `OPC_DEC_HI) begin
         r = OP_DEC;
      end else if (w[13:8] == `OPC_DECSKIP_HI) begin
         r = OP_DECSKIP;
      end else if (w[13:8] == `OPC_INCSKIP_HI) begin
         r = OP_INCSKIP;
      end else if (w[13:11] == `OPC_BRANCH_HI) begin
         r = OP_BRANCH;
      end else if (w[13:8] == `OPC_ORLIT_HI) begin
         r = OP_ORLIT;
      end
      return r;
   endfunction

   exec_state_t state;
   exec_state_t next_state;
   exec_op_t op_q;
   logic [13:0] instr_q;
   logic [6:0] latch_q;
   logic issue;
   logic [DATA_W-1:0] file_rd;
   logic [DATA_W-1:0] result;
   logic [ADDR_W-1:0] f_addr;
   logic dest_file;
   logic ram_wr_en;
   logic [ADDR_W-1:0] ram_wr_addr;
   logic [DATA_W-1:0] ram_wr_data;

   // Taken only while not busy, so a word offered in a flushed slot is dropped
   assign issue = i_instr_valid && !o_busy;
   assign f_addr = instr_q[ADDR_W-1:0]; // RULE2
   assign dest_file = instr_q[`DEST_BIT]; // RULE2

   // ************************************************************
   // Issue register: operand fetch occurs in the issue cycle
   // ************************************************************

   // Capture instruction; the execute stage sees it one cycle later
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         op_q <= OP_NONE;
         instr_q <= 14'h0000;
         latch_q <= 7'h00;
      end else if (issue) begin
         op_q <= decode(i_instr);
         instr_q <= i_instr;
         latch_q <= i_upper_jump_latch;
      end else begin
         op_q <= OP_NONE;
      end
   end

   // Unknown opcodes execute as no_operation and are flagged
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_unknown_op <= 1'b0;
      end else begin
         o_unknown_op <= issue && (decode(i_instr) == OP_NONE);
      end
   end

   exec_file_ram #(
      .ADDR_W(ADDR_W),
      .DATA_W(DATA_W)
   ) u_ram (
      .i_ref_clk(i_ref_clk),
      .i_rd_addr(i_instr[ADDR_W-1:0]),
      .o_rd_data(file_rd),
      .i_wr_en(ram_wr_en),
      .i_wr_addr(ram_wr_addr),
      .i_wr_data(ram_wr_data)
   );

   // ************************************************************
   // Execute
   // ************************************************************

   // Arithmetic result; 8-bit sums wrap modulo 256
   always_comb begin
      case (op_q)
         OP_DEC: result = file_rd - 8'h01; // RULE3 RULE12
         OP_DECSKIP: result = file_rd - 8'h01; // RULE5 RULE12
         OP_INCSKIP: result = file_rd + 8'h01; // RULE7 RULE12
         OP_ORLIT: result = o_accumulator | instr_q[7:0]; // RULE11
         default: result = 8'h00; // RULE1 RULE4
      endcase
   end

   // File write-back: clear always writes, decrement and skip forms by destination bit
   always_comb begin
      o_file_wr.en = 1'b0;
      o_file_wr.addr = f_addr;
      o_file_wr.data = result;
      case (op_q)
         OP_CLR_FILE: o_file_wr.en = 1'b1; // RULE1
         OP_DEC, OP_DECSKIP, OP_INCSKIP: o_file_wr.en = dest_file; // RULE3 RULE5 RULE7
         default: o_file_wr.en = 1'b0;
      endcase
   end

   // Execution write-back has priority over the preload port
   assign ram_wr_en = o_file_wr.en | i_ext_wr_en;
   assign ram_wr_addr = o_file_wr.en ? o_file_wr.addr : i_ext_wr_addr;
   assign ram_wr_data = o_file_wr.en ? o_file_wr.data : i_ext_wr_data;

   // Accumulator updates
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_accumulator <= `ACC_RESET;
      end else begin
         case (op_q)
            OP_CLR_ACC: o_accumulator <= 8'h00; // RULE4
            OP_ORLIT: o_accumulator <= result; // RULE11
            OP_DEC, OP_DECSKIP, OP_INCSKIP: begin
               if (!dest_file) begin
                  o_accumulator <= result; // RULE3 RULE5 RULE7
               end
            end
            default: o_accumulator <= o_accumulator;
         endcase
      end
   end

   // Zero flag: skip forms and branch leave it alone
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_zero_flag <= `ZERO_RESET;
      end else begin
         case (op_q)
            OP_CLR_FILE, OP_CLR_ACC: o_zero_flag <= 1'b1; // RULE1 RULE4
            OP_DEC, OP_ORLIT: o_zero_flag <= (result == 8'h00); // RULE3 RULE11 RULE12
            default: o_zero_flag <= o_zero_flag; // RULE5 RULE7
         endcase
      end
   end

   // Branch target: low bits from the literal, high bits from latch 6:3
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pc_load <= '0;
      end else begin
         o_pc_load.en <= (op_q == OP_BRANCH); // RULE9
         o_pc_load.target <= {latch_q[`LATCH_HI_BIT:`LATCH_LO_BIT],
                              instr_q[`BRANCH_K_W-1:0]}; // RULE9
      end
   end

   // ************************************************************
   // Sequencing: a zero skip result and any branch cost one flushed cycle
   // ************************************************************

   // Next state: a zero skip result or any branch flushes the next slot
   always_comb begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (op_q == OP_BRANCH) begin
               next_state = ST_FLUSH; // RULE10
            end else if ((op_q == OP_DECSKIP || op_q == OP_INCSKIP) && result == 8'h00) begin
               next_state = ST_FLUSH; // RULE6 RULE8
            end
         end
         ST_FLUSH: next_state = ST_RUN;
         ST_IDLE: next_state = ST_RUN;
         default: next_state = ST_RUN;
      endcase
   end

   // State register; reset parks in IDLE so busy holds off the first fetch
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Flush cycle executes as no_operation; busy holds off the fetch side
   assign o_no_operation = (state == ST_FLUSH); // RULE6 RULE8 RULE10
   assign o_busy = (state != ST_RUN) || (next_state == ST_FLUSH);
endmodule

// ===== design/exec_file_ram.sv
// Small file register memory with registered read data
`timescale 1ns/100ps
module exec_file_ram #(
   parameter int ADDR_W = 7,
   parameter int DATA_W = 8
) (
   // Clock
   input wire logic i_ref_clk,
   // Read port
   input wire logic [ADDR_W-1:0] i_rd_addr,
   output logic [DATA_W-1:0] o_rd_data,
   // Write port
   input wire logic i_wr_en,
   input wire logic [ADDR_W-1:0] i_wr_addr,
   input wire logic [DATA_W-1:0] i_wr_data
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // Write, then registered read; no reset, contents are software state
   always_ff @(posedge i_ref_clk) begin
      if (i_wr_en) begin
         mem[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= mem[i_rd_addr];
   end
endmodule

// ===== test/core_exec_properties.sv
// Concurrent checks on the ports of the execution subset block
`timescale 1ns/100ps
module core_exec_properties #(
   parameter int ADDR_W = 7,
   parameter int DATA_W = 8
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Instruction stream
   input wire logic i_instr_valid,
   input wire logic [13:0] i_instr,
   input wire logic [6:0] i_upper_jump_latch,
   // Results
   input wire logic [DATA_W-1:0] o_accumulator,
   input wire logic o_zero_flag,
   input wire core_exec_pkg::pc_load_t o_pc_load,
   input wire core_exec_pkg::file_wr_t o_file_wr,
   input wire logic o_no_operation,
   input wire logic o_busy
);
   import core_exec_pkg::*;
   logic taken;
   logic [14:0] exp_target;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // ************
   // Helper logic
   // ************
   // Accepted only while free; a stalled word must not count
   assign taken = i_instr_valid && !o_busy;
   // The target is frozen at issue, since the latch may move later
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         exp_target <= 15'h0000;
      end else if (taken) begin
         exp_target <= {i_upper_jump_latch[6:3], i_instr[10:0]};
      end
   end
   sequence flush_s;
      o_busy ##1 o_busy ##1 !o_busy;
   endsequence
   sequence branch_s;
      ##[1:3] (o_pc_load.en && o_pc_load.target == exp_target);
   endsequence
   // ************
   // Assertions
   // ************
   clear_file_a: assert property (taken && i_instr[13:7] == 7'h03 |->
      ##[1:2] (o_file_wr.en && o_file_wr.data == 8'h00)) else $error("clear wrote nonzero");
   clear_zero_a: assert property (taken && i_instr[13:7] == 7'h03 |->
      ##[1:3] o_zero_flag) else $error("clear left zero flag low");
   clear_acc_a: assert property (taken && i_instr == 14'h0100 |->
      ##[1:3] (o_accumulator == 8'h00 && o_zero_flag)) else $error("accumulator not cleared");
   or_zero_a: assert property (taken && i_instr[13:8] == 6'h38 |->
      ##2 (o_zero_flag == (o_accumulator == 8'h00))) else $error("zero flag mismatch");
   skip_flags_a: assert property (taken && i_instr[13:9] inside {5'h05, 5'h07} |->
      ##1 $stable(o_zero_flag) [*3]) else $error("skip changed zero flag");
   flush_len_a: assert property ($rose(o_busy) |-> flush_s)
      else $error("flush slot length wrong");
   nop_busy_a: assert property (o_no_operation |-> o_busy ##1 !o_no_operation)
      else $error("no operation outside stall");
   branch_tgt_a: assert property (taken && i_instr[13:11] == 3'b101 |-> branch_s)
      else $error("branch target wrong");
   load_nop_a: assert property (o_pc_load.en |-> o_no_operation)
      else $error("branch without flushed slot");
endmodule
bind core_exec_subset core_exec_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
   .i_ref_clk, .i_rst_n, .i_instr_valid, .i_instr, .i_upper_jump_latch, .o_accumulator,
   .o_zero_flag, .o_pc_load, .o_file_wr, .o_no_operation, .o_busy);

// ===== test/tb_top.sv
// Self-checking bench for the execution subset block
`timescale 1ns/100ps
module tb_top;
   import core_exec_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic vld = 1'b0;
   logic ext_en = 1'b0;
   logic [13:0] instr = 14'h0000;
   logic [6:0] latch = 7'h00;
   logic [6:0] ext_addr = 7'h00;
   logic [7:0] ext_data = 8'h00;
   logic [7:0] acc, exp_acc;
   logic z, exp_z, no_operation, busy, got_nop, unk, got_unk;
   pc_load_t pcl, got_pc;
   file_wr_t fw, got_fw;
   int err_count = 0;
   int cmp_count = 0;
   int nbusy;
   core_exec_subset dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_instr_valid(vld), .i_instr(instr),
      .i_upper_jump_latch(latch), .i_ext_wr_en(ext_en), .i_ext_wr_addr(ext_addr),
      .i_ext_wr_data(ext_data), .o_accumulator(acc), .o_zero_flag(z), .o_pc_load(pcl),
      .o_file_wr(fw), .o_no_operation(no_operation), .o_busy(busy), .o_unknown_op(unk));
   // 20 MHz clock
   initial begin
      forever #25 clk = ~clk;
   end
   // ************
   // Shared tasks
   // ************
   task automatic results;
      if (err_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Preload goes through the side port, one cycle per byte
   task automatic load(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      ext_en = 1'b1;
      ext_addr = a;
      ext_data = d;
      @(posedge clk) #1;
      ext_en = 1'b0;
   endtask
   // Issue one word, then record four cycles of outputs at the falling edge
   task automatic run(input logic [13:0] w, input logic [6:0] l);
      int n;
      n = 0;
      @(posedge clk) #1;
      while (busy !== 1'b0 && n < 10) begin
         @(posedge clk) #1;
         n++;
      end
      if (n == 10) begin
         err_count++;
         results();
      end
      vld = 1'b1;
      instr = w;
      latch = l;
      @(posedge clk) #1;
      vld = 1'b0;
      got_fw = '0;
      got_pc = '0;
      got_nop = 1'b0;
      got_unk = 1'b0;
      nbusy = 0;
      repeat (4) begin
         @(negedge clk);
         if (fw.en === 1'b1) got_fw = fw;
         if (pcl.en === 1'b1) got_pc = pcl;
         if (no_operation === 1'b1) got_nop = 1'b1;
         if (unk === 1'b1) got_unk = 1'b1;
         if (busy === 1'b1) nbusy++;
      end
   endtask
   // A flushed slot always costs exactly two stalled cycles
   task automatic ends(input file_wr_t efw, input pc_load_t epc, input logic enop);
      chk(got_fw, efw);
      chk(got_pc, epc);
      chk(got_nop, enop);
      chk(nbusy, enop ? 2 : 0);
      chk(acc, exp_acc);
      chk(z, exp_z);
      chk(got_unk, 1'b0);
   endtask
   // ************
   // Scenarios
   // ************
   task automatic t_clear_file;
      load(7'h7f, 8'h5a);
      run({7'h03, 7'h7f}, 7'h00);
      exp_z = 1'b1;
      ends({1'b1, 7'h7f, 8'h00}, '0, 1'b0);
   endtask
   task automatic t_literal;
      run({6'h38, 8'h81}, 7'h00);
      exp_acc = 8'h81;
      exp_z = 1'b0;
      ends('0, '0, 1'b0);
      run(14'h0100, 7'h00);
      exp_acc = 8'h00;
      exp_z = 1'b1;
      ends('0, '0, 1'b0);
      run({6'h38, 8'h00}, 7'h00);
      ends('0, '0, 1'b0);
   endtask
   // To the accumulator, to zero in place, then address zero wraps in place
   task automatic t_decrement;
      load(7'h10, 8'h02);
      run({6'h03, 1'b0, 7'h10}, 7'h00);
      exp_acc = 8'h01;
      exp_z = 1'b0;
      ends('0, '0, 1'b0);
      load(7'h11, 8'h01);
      run({6'h03, 1'b1, 7'h11}, 7'h00);
      exp_z = 1'b1;
      ends({1'b1, 7'h11, 8'h00}, '0, 1'b0);
      load(7'h00, 8'h00);
      run({6'h03, 1'b1, 7'h00}, 7'h00);
      exp_z = 1'b0;
      ends({1'b1, 7'h00, 8'hff}, '0, 1'b0);
   endtask
   // Zero and nonzero results for both skips, decrement-skip entered with the flag low, increment-skip with it high
   task automatic t_skips;
      logic [7:0] v [4] = '{8'h01, 8'h05, 8'h7f, 8'hff};
      logic [3:0] dsel = 4'b1001;
      logic [7:0] res;
      file_wr_t efw;
      for (int i = 0; i < 4; i++) begin
         if (i == 2) begin
            run(14'h0100, 7'h00);
            exp_acc = 8'h00;
            exp_z = 1'b1;
         end
         load(7'h20 + 7'(i), v[i]);
         run({(i < 2) ? 6'h0b : 6'h0f, dsel[i], 7'h20 + 7'(i)}, 7'h00);
         res = (i < 2) ? v[i] - 8'h01 : v[i] + 8'h01;
         efw = '0;
         if (dsel[i]) efw = {1'b1, 7'h20 + 7'(i), res};
         else exp_acc = res;
         ends(efw, '0, res == 8'h00);
      end
   endtask
   task automatic t_branch;
      run({3'b101, 11'h7ff}, 7'h5a);
      ends('0, {1'b1, 4'hb, 11'h7ff}, 1'b1);
      run({3'b101, 11'h000}, 7'h07);
      ends('0, {1'b1, 15'h0000}, 1'b1);
   endtask
   // A word held up behind a branch must be dropped, not run in the flushed slot
   task automatic t_refused;
      @(posedge clk) #1;
      vld = 1'b1;
      instr = {3'b101, 11'h155};
      latch = 7'h00;
      @(posedge clk) #1;
      instr = {6'h38, 8'hff};
      @(posedge clk) #1;
      chk(no_operation, 1'b1);
      @(posedge clk) #1;
      vld = 1'b0;
      @(posedge clk) #1;
      @(posedge clk) #1;
      chk(acc, exp_acc);
      chk(z, exp_z);
      run(14'h3fff, 7'h00);
      chk(got_unk, 1'b1);
      chk(acc, exp_acc);
      chk(z, exp_z);
   endtask
   // Main sequence
   initial begin
      exp_acc = 8'h00;
      exp_z = 1'b0;
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      t_clear_file();
      t_literal();
      t_decrement();
      t_skips();
      t_branch();
      t_refused();
      results();
   end
endmodule
